// *** inc/prsg_defs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef PRSG_DEFS_SVH
`define PRSG_DEFS_SVH
`define PRSG_OFF_RUN_EN 8'h00
`define PRSG_OFF_SLEEP_EN 8'h04
`define PRSG_OFF_SLEEP_SET 8'h08
`define PRSG_OFF_SLEEP_CLR 8'h0c
`define PRSG_OFF_SOFT_RST 8'h10
`define PRSG_OFF_CTRL 8'h14
`define PRSG_OFF_READY 8'h18
`define PRSG_OFF_STATUS 8'h1c
`define PRSG_CTRL_AGC_BIT 0
`define PRSG_STATUS_SLEEP_BIT 0
`define PRSG_STATUS_WAKE_BIT 1
`define PRSG_RUN_EN_RESET 32'h0000_0000
`define PRSG_SLEEP_EN_RESET 32'hffff_ffff
`define PRSG_AGC_RESET 1'b0
`define PRSG_RST_CYCLES 4
`define PRSG_SETTLE_CYCLES 2
`endif

// *** inc/prsg_pkg.sv ***
// Types shared by the reset and sleep gating design
package prsg_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] addr_t;
  typedef logic [3:0] sel_t;
  // One-hot register select
  typedef enum logic [8:0] {
    SEL_NONE = 9'h000,
    SEL_RUN_EN = 9'h001,
    SEL_SLEEP_EN = 9'h002,
    SEL_SLEEP_SET = 9'h004,
    SEL_SLEEP_CLR = 9'h008,
    SEL_SOFT_RST = 9'h010,
    SEL_CTRL = 9'h020,
    SEL_READY = 9'h040,
    SEL_STATUS = 9'h080
  } reg_sel_t;
endpackage : prsg_pkg

// *** inc/periph_gate_if.sv ***
// Control and status bundle between the register file and the slot logic
`timescale 1ns/100ps
interface periph_gate_if #(parameter int N = 32);
  logic [N-1:0] run_en;
  logic [N-1:0] sleep_en;
  logic [N-1:0] rst_req;
  logic agc;
  logic cpu_sleep;
  logic [N-1:0] clk_en;
  logic [N-1:0] rst;
  logic [N-1:0] ready;
  modport ctrl (output run_en, sleep_en, rst_req, agc, cpu_sleep,
    input clk_en, rst, ready);
  modport slot (input run_en, sleep_en, rst_req, agc, cpu_sleep,
    output clk_en, rst, ready);
endinterface : periph_gate_if

// *** verilog/periph_slot.sv ***
// Per-peripheral reset pulse, settle timer, clock enable and ready status
`timescale 1ns/100ps
`include "prsg_defs.svh"
module periph_slot #(
  parameter int N = 32,
  parameter int CW = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  periph_gate_if.slot gate
);
  import prsg_pkg::*;

  localparam logic [CW-1:0] RST_LOAD = CW'(`PRSG_RST_CYCLES);
  localparam logic [CW-1:0] SETTLE_LOAD = CW'(`PRSG_SETTLE_CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] rst_cnt [N];
  logic [CW-1:0] settle_cnt [N];
  logic [N-1:0] run_en_d;
  logic [N-1:0] settle_load;

  // Settling restarts on enable or at the last reset cycle
  always_comb begin
    for (int i = 0; i < N; i++) begin
      settle_load[i] = (gate.run_en[i] & ~run_en_d[i]) |
        ((rst_cnt[i] == ONE) & ~gate.rst_req[i]);
    end
  end

  // Reset pulse counters, each peripheral on its own
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < N; i++) rst_cnt[i] <= '0;
      gate.rst <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (gate.rst_req[i]) begin
          rst_cnt[i] <= RST_LOAD;
        end else if (rst_cnt[i] != '0) begin
          rst_cnt[i] <= rst_cnt[i] - ONE;
        end
        gate.rst[i] <= gate.rst_req[i] | (rst_cnt[i] > ONE);
      end
    end
  end

  // Settle timers and ready status
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < N; i++) settle_cnt[i] <= '0;
      run_en_d <= '0;
      gate.ready <= '0;
    end else begin
      run_en_d <= gate.run_en;
      for (int i = 0; i < N; i++) begin
        if (settle_load[i]) begin
          settle_cnt[i] <= SETTLE_LOAD;
        end else if (settle_cnt[i] != '0) begin
          settle_cnt[i] <= settle_cnt[i] - ONE;
        end
        gate.ready[i] <= gate.run_en[i] & ~gate.rst_req[i] & (rst_cnt[i] == '0) &
          (settle_cnt[i] == '0) & ~settle_load[i];
      end
    end
  end

  // Clock from run enable, cut in sleep with gating on and no sleep enable; a reset pulse does not hold it on
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gate.clk_en <= '0;
    end else begin
      gate.clk_en <= gate.run_en &
        ~({N{gate.cpu_sleep & gate.agc}} & ~gate.sleep_en);
    end
  end

  rst_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    gate.rst_req[0] |=> gate.rst[0] [*4])
    else $error("reset pulse shorter than four cycles");
  rst_isolated_a: assert property (@(posedge i_clk) disable iff (i_rst)
    gate.rst_req[0] && !gate.rst_req[1] && !gate.rst[1] |=> !gate.rst[1])
    else $error("reset leaked to a neighbour");
  not_ready_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!gate.run_en[0] || gate.rst[0]) |=> !gate.ready[0])
    else $error("ready while disabled or in reset");
  sleep_stop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    gate.cpu_sleep && gate.agc && !gate.sleep_en[0] |=> !gate.clk_en[0])
    else $error("clock kept in sleep without sleep enable");
  sleep_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    gate.cpu_sleep && gate.sleep_en[0] && gate.run_en[0] |=> gate.clk_en[0])
    else $error("sleep enabled peripheral lost its clock");
  run_resume_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(gate.cpu_sleep) && gate.run_en[0] |-> ##1 gate.clk_en[0])
    else $error("peripheral did not resume after sleep");
  agc_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !gate.agc && gate.run_en[0] |=> gate.clk_en[0])
    else $error("clock gated while gating is off");
endmodule : periph_slot

// *** verilog/periph_reset_sleep_gating.sv ***
// Wishbone register file for peripheral soft reset and sleep clock gating
`timescale 1ns/100ps
`include "prsg_defs.svh"
module periph_reset_sleep_gating #(
  parameter int N = 32
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire prsg_pkg::addr_t I_WB_ADR,
  input wire prsg_pkg::sel_t I_WB_SEL,
  input wire prsg_pkg::word_t I_WB_DAT,
  output prsg_pkg::word_t O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_CPU_SLEEP,
  input wire logic [N-1:0] I_PERIPH_WAKE,
  output logic [N-1:0] O_PERIPH_CLK_EN,
  output logic [N-1:0] O_PERIPH_RST,
  output logic [N-1:0] O_PERIPH_READY,
  output logic O_CPU_WAKE
);
  import prsg_pkg::*;

  periph_gate_if #(.N(N)) gate ();

  logic wb_req;
  logic wr_take;
  reg_sel_t sel;
  logic [N-1:0] periph_run_clock_enable;
  logic [N-1:0] periph_sleep_clock_enable;
  logic [N-1:0] periph_soft_reset_request;
  logic auto_clock_gating_enable;
  logic [N-1:0] wake_src;
  word_t next_rdata;

  // Byte lanes from sel, used by every writable register except the control register
  function automatic word_t lane_mask(input sel_t s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  // Merge write data into a stored word under the byte lanes
  function automatic word_t merge(input word_t old, input word_t wd, input sel_t s);
    return (old & ~lane_mask(s)) | (wd & lane_mask(s));
  endfunction : merge

  // Widen a peripheral vector to a bus word
  function automatic word_t widen(input logic [N-1:0] v);
    word_t w;
    w = '0;
    w[N-1:0] = v;
    return w;
  endfunction : widen

  // Address decode
  always_comb begin
    unique case (I_WB_ADR)
      `PRSG_OFF_RUN_EN: sel = SEL_RUN_EN;
      `PRSG_OFF_SLEEP_EN: sel = SEL_SLEEP_EN;
      `PRSG_OFF_SLEEP_SET: sel = SEL_SLEEP_SET;
      `PRSG_OFF_SLEEP_CLR: sel = SEL_SLEEP_CLR;
      `PRSG_OFF_SOFT_RST: sel = SEL_SOFT_RST;
      `PRSG_OFF_CTRL: sel = SEL_CTRL;
      `PRSG_OFF_READY: sel = SEL_READY;
      `PRSG_OFF_STATUS: sel = SEL_STATUS;
      default: sel = SEL_NONE;
    endcase
  end

  assign wb_req = I_WB_CYC & I_WB_STB;
  // Writes land on the edge that sees ack high, as the master samples it
  assign wr_take = wb_req & I_WB_WE & O_WB_ACK;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= wb_req & ~O_WB_ACK;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    next_rdata = '0;
    unique case (sel)
      SEL_RUN_EN: next_rdata = widen(periph_run_clock_enable);
      SEL_SLEEP_EN: next_rdata = widen(periph_sleep_clock_enable);
      SEL_SLEEP_SET: next_rdata = widen(periph_sleep_clock_enable);
      SEL_SLEEP_CLR: next_rdata = widen(periph_sleep_clock_enable);
      SEL_SOFT_RST: next_rdata = widen(gate.rst);
      SEL_CTRL: next_rdata[`PRSG_CTRL_AGC_BIT] = auto_clock_gating_enable;
      SEL_READY: next_rdata = widen(gate.ready);
      SEL_STATUS: begin
        next_rdata[`PRSG_STATUS_SLEEP_BIT] = I_CPU_SLEEP;
        next_rdata[`PRSG_STATUS_WAKE_BIT] = O_CPU_WAKE;
      end
      SEL_NONE: next_rdata = '0;
    endcase
  end

  // Read data captured with the ack
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_DAT <= '0;
    end else if (wb_req & ~O_WB_ACK & ~I_WB_WE) begin
      O_WB_DAT <= next_rdata;
    end
  end

  // Run enables
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      periph_run_clock_enable <= N'(`PRSG_RUN_EN_RESET);
    end else if (wr_take && sel == SEL_RUN_EN) begin
      periph_run_clock_enable <= N'(merge(widen(periph_run_clock_enable),
        I_WB_DAT, I_WB_SEL));
    end
  end

  // Sleep enables: direct write, set-only and clear-only views
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      periph_sleep_clock_enable <= N'(`PRSG_SLEEP_EN_RESET);
    end else if (wr_take) begin
      unique case (sel)
        SEL_SLEEP_EN: periph_sleep_clock_enable <= N'(merge(
          widen(periph_sleep_clock_enable), I_WB_DAT, I_WB_SEL));
        SEL_SLEEP_SET: periph_sleep_clock_enable <= periph_sleep_clock_enable |
          N'(I_WB_DAT & lane_mask(I_WB_SEL));
        SEL_SLEEP_CLR: periph_sleep_clock_enable <= periph_sleep_clock_enable &
          ~N'(I_WB_DAT & lane_mask(I_WB_SEL));
        default: periph_sleep_clock_enable <= periph_sleep_clock_enable;
      endcase
    end
  end

  // Global gating enable; toggling it leaves the sleep enables untouched
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      auto_clock_gating_enable <= `PRSG_AGC_RESET;
    end else if (wr_take && sel == SEL_CTRL && I_WB_SEL[0]) begin
      auto_clock_gating_enable <= I_WB_DAT[`PRSG_CTRL_AGC_BIT];
    end
  end

  // Write-one soft reset request, a single-cycle pulse per named bit
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      periph_soft_reset_request <= '0;
    end else if (wr_take && sel == SEL_SOFT_RST) begin
      periph_soft_reset_request <= N'(I_WB_DAT & lane_mask(I_WB_SEL));
    end else begin
      periph_soft_reset_request <= '0;
    end
  end

  // Core sleep is on this clock, so no synchroniser
  assign gate.run_en = periph_run_clock_enable;
  assign gate.sleep_en = periph_sleep_clock_enable;
  assign gate.rst_req = periph_soft_reset_request;
  assign gate.agc = auto_clock_gating_enable;
  assign gate.cpu_sleep = I_CPU_SLEEP;

  periph_slot #(.N(N), .CW(4)) u_slot (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .gate(gate)
  );

  assign O_PERIPH_CLK_EN = gate.clk_en;
  assign O_PERIPH_RST = gate.rst;
  assign O_PERIPH_READY = gate.ready;

  // Only a peripheral that still has its clock can wake the core
  assign wake_src = I_PERIPH_WAKE & gate.clk_en;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CPU_WAKE <= 1'b0;
    end else begin
      O_CPU_WAKE <= I_CPU_SLEEP & (|wake_src);
    end
  end

  ack_single_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");
  ack_timely_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    wb_req && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack missing one cycle after request");
  wake_path_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CPU_SLEEP && (|(I_PERIPH_WAKE & O_PERIPH_CLK_EN)) |=> O_CPU_WAKE)
    else $error("wake event not passed to the core");
  sleep_kept_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    !wr_take |=> $stable(periph_sleep_clock_enable))
    else $error("sleep enables changed without a write");
  gated_only_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    !auto_clock_gating_enable && I_CPU_SLEEP |=> O_PERIPH_CLK_EN == $past(periph_run_clock_enable))
    else $error("sleep enables acted with gating off");
endmodule : periph_reset_sleep_gating

// *** dv/periph_model.sv ***
// Behavioural bank of peripherals that sits behind the gating block
`timescale 1ns/100ps
module periph_model #(
  parameter int N = 32
) (
  input wire logic i_clk,
  input wire logic [N-1:0] i_clk_en,
  input wire logic [N-1:0] i_rst,
  input wire logic [N-1:0] i_wake_cmd,
  output logic [N-1:0] o_wake
);
  logic [7:0] cnt [N];
  // Each peripheral advances only on enabled clocks, so gated state is held
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < N; i++) begin
      if (i_rst[i]) begin
        cnt[i] <= 8'h00;
      end else if (i_clk_en[i]) begin
        cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end
  // Wake is registered: an unclocked peripheral cannot change its request
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < N; i++) begin
      if (i_clk_en[i]) begin
        o_wake[i] <= i_wake_cmd[i];
      end
    end
  end
endmodule : periph_model

// *** dv/test_periph_reset_sleep_gating.sv ***
// Register-level bench for the peripheral reset and sleep gating block
`timescale 1ns/100ps
`include "prsg_defs.svh"
module test_periph_reset_sleep_gating;
  import prsg_pkg::*;
  logic I_CLK, I_RST, I_WB_CYC, I_WB_STB, I_WB_WE, I_CPU_SLEEP, O_WB_ACK, O_CPU_WAKE;
  addr_t I_WB_ADR;
  sel_t I_WB_SEL, lanes;
  word_t I_WB_DAT, O_WB_DAT;
  logic [31:0] wake, clk_en, prst, ready, wake_cmd;
  int failures, comparisons, cycles, n;
  logic [7:0] frozen;

  periph_reset_sleep_gating #(.N(32)) DUT (.I_CLK(I_CLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
    .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
    .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_CPU_SLEEP(I_CPU_SLEEP),
    .I_PERIPH_WAKE(wake), .O_PERIPH_CLK_EN(clk_en), .O_PERIPH_RST(prst),
    .O_PERIPH_READY(ready), .O_CPU_WAKE(O_CPU_WAKE));
  periph_model #(.N(32)) PEER (.i_clk(I_CLK), .i_clk_en(clk_en), .i_rst(prst),
    .i_wake_cmd(wake_cmd), .o_wake(wake));

  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // One classic cycle; request held until ack is seen at a rising edge
  task automatic wb_cycle(input logic we, input addr_t a, input word_t d, output word_t q);
    @(posedge I_CLK);
    I_WB_CYC <= 1'b1;
    I_WB_STB <= 1'b1;
    I_WB_WE <= we;
    I_WB_ADR <= a;
    I_WB_SEL <= lanes;
    I_WB_DAT <= d;
    do @(posedge I_CLK); while (O_WB_ACK !== 1'b1);
    q = O_WB_DAT;
    I_WB_CYC <= 1'b0;
    I_WB_STB <= 1'b0;
    I_WB_WE <= 1'b0;
  endtask : wb_cycle

  task automatic wb_write(input addr_t a, input word_t d);
    word_t q;
    wb_cycle(1'b1, a, d, q);
  endtask : wb_write

  task automatic wb_read(input addr_t a, input word_t exp, input string what);
    word_t q;
    wb_cycle(1'b0, a, 32'h0000_0000, q);
    check(what, q, exp);
  endtask : wb_read

  // Outputs are registered; three edges cover their one-cycle lag
  task automatic settle;
    repeat (3) @(posedge I_CLK);
  endtask : settle

  // Hang guard well above the hundred or so cycles the sequence needs
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    I_RST = 1'b1;
    I_WB_CYC = 1'b0;
    I_WB_STB = 1'b0;
    I_WB_WE = 1'b0;
    I_WB_ADR = 8'h00;
    I_WB_SEL = 4'h0;
    I_WB_DAT = 32'h0000_0000;
    I_CPU_SLEEP = 1'b0;
    wake_cmd = 32'h0000_0000;
    lanes = 4'hf;
    repeat (16) @(posedge I_CLK);
    I_RST <= 1'b0;
    // Reset contents, plus an unmapped offset that reads zero
    wb_read(`PRSG_OFF_RUN_EN, `PRSG_RUN_EN_RESET, "run_en");
    wb_read(`PRSG_OFF_SLEEP_EN, `PRSG_SLEEP_EN_RESET, "sleep_en");
    wb_read(`PRSG_OFF_CTRL, 32'h0000_0000, "ctrl");
    wb_write(8'h20, 32'hffff_ffff);
    wb_read(8'h20, 32'h0000_0000, "unmapped");
    check("ready_off", ready, 32'h0000_0000);
    // Enable peripherals 0 and 2 only
    wb_write(`PRSG_OFF_RUN_EN, 32'h0000_0005);
    settle();
    check("clk_en_run", clk_en, 32'h0000_0005);
    settle();
    wb_read(`PRSG_OFF_READY, 32'h0000_0005, "ready_reg");
    // Soft reset of peripheral 0: pulse length, isolation, ready drop
    wb_write(`PRSG_OFF_SOFT_RST, 32'h0000_0001);
    for (n = 0; n < 8 && prst[0] !== 1'b1; n++) @(posedge I_CLK);
    check("rst_others", prst, 32'h0000_0001);
    check("ready_in_rst", ready, 32'h0000_0004);
    for (n = 0; n < 20 && prst[0] === 1'b1; n++) @(posedge I_CLK);
    check("rst_len", n, `PRSG_RST_CYCLES);
    check("state_cleared", {24'h0, PEER.cnt[0]} < 32'h3, 32'h1);
    settle();
    check("ready_back", ready, 32'h0000_0005);
    // Peripheral 0 loses its sleep clock; settings survive gating off
    wb_write(`PRSG_OFF_SLEEP_CLR, 32'h0000_0001);
    wb_read(`PRSG_OFF_SLEEP_SET, 32'hffff_fffe, "sleep_clr");
    // Peripheral 0 raises its wake while still clocked, so the level outlives its clock
    I_CPU_SLEEP <= 1'b1;
    wake_cmd <= 32'h0000_0001;
    settle();
    check("agc_off", clk_en, 32'h0000_0005);
    check("agc_off_wake", O_CPU_WAKE, 1'b1);
    wb_read(`PRSG_OFF_SLEEP_EN, 32'hffff_fffe, "kept");
    wb_write(`PRSG_OFF_CTRL, 32'h0000_0001);
    settle();
    check("agc_on", clk_en, 32'h0000_0004);
    frozen = PEER.cnt[0];
    // A gated peripheral cannot wake, even with its request held; a clocked one can
    settle();
    check("gated_wake", O_CPU_WAKE, 1'b0);
    check("held", PEER.cnt[0], frozen);
    wake_cmd <= 32'h0000_0004;
    settle();
    check("wake", O_CPU_WAKE, 1'b1);
    wb_read(`PRSG_OFF_STATUS, 32'h0000_0003, "status");
    wake_cmd <= 32'h0000_0000;
    I_CPU_SLEEP <= 1'b0;
    settle();
    check("resume", clk_en, 32'h0000_0005);
    check("resume_cnt", PEER.cnt[0] > frozen, 1'b1);
    // Setting the sleep enable keeps the clock through sleep
    wb_write(`PRSG_OFF_SLEEP_SET, 32'h0000_0001);
    I_CPU_SLEEP <= 1'b1;
    settle();
    check("sleep_set", clk_en, 32'h0000_0005);
    // Byte lanes mask the clear word, the control word and the reset word alike
    lanes = 4'he;
    wb_write(`PRSG_OFF_SLEEP_CLR, 32'hffff_ffff);
    wb_write(`PRSG_OFF_CTRL, 32'h0000_0000);
    wb_write(`PRSG_OFF_SOFT_RST, 32'h0000_0001);
    lanes = 4'hf;
    wb_read(`PRSG_OFF_SOFT_RST, 32'h0000_0000, "lane_rst");
    wb_read(`PRSG_OFF_SLEEP_EN, 32'h0000_00ff, "lane_sleep");
    wb_read(`PRSG_OFF_CTRL, 32'h0000_0001, "lane_ctrl");
    check("lane_clk", clk_en, 32'h0000_0005);
    end_of_test();
  end
endmodule : test_periph_reset_sleep_gating
